// ---- hw/lp_mode_pkg.sv ----
package lp_mode_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_WAKE_INT = 0;
  localparam int IRQ_WAKE_LEAKAGE_WAKE_UNIT = 1;
  localparam int IRQ_STOP_ENTRY = 2;

  // ------------------------------------------------------------
  // clock plan for low-power run
  // ------------------------------------------------------------
  localparam int FAST_IRC_KHZ = 4000;
  localparam int BUS_MAX_KHZ = 800;
  localparam int FLASH_KHZ = 1000;
  // bus must stay strictly below the limit, hence the extra step
  localparam int BUS_DIV_INT = FAST_IRC_KHZ / BUS_MAX_KHZ + 1;
  localparam int FLASH_DIV_INT = FAST_IRC_KHZ / FLASH_KHZ;
  localparam logic [3:0] BUS_DIV = 4'(BUS_DIV_INT);
  localparam logic [3:0] FLASH_DIV = 4'(FLASH_DIV_INT);
  localparam logic [3:0] DIV_FULL = 4'h1;

  typedef enum logic [2:0] {
    STOP_VERY_LOW_POWER_STOP,
    STOP_LLS,
    STOP_DEEP_LEAKAGE_STOP_3,
    STOP_DEEP_LEAKAGE_STOP_1,
    STOP_DEEP_LEAKAGE_STOP_0
  } stop_sel_e;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_STOP,
    ST_RESTORE,
    ST_RELEASE
  } pm_state_e;

  // software control word
  typedef struct packed {
    logic uart_clk_en;
    logic uart_en;
    logic tpm_clk_en;
    logic tpm_en;
    logic ext_clk;
    logic [1:0] stop_sel;
    logic low_power_run;
  } ctrl_s;

  // every power control the controller drives into the chip; wake reset, flag and irq are separate ports
  typedef struct packed {
    logic core_sleep;
    logic core_deep;
    logic sys_clk_en;
    logic nested_interrupt_ctrl_en;
    logic async_wake_ctrl_en;
    logic leakage_wake_unit_en;
    logic periph_clk_en;
    logic tpm_clk_en;
    logic uart_clk_en;
    logic adc_en;
    logic osc_en;
    logic cmp_en;
    logic lvd_en;
    logic reg_low_power;
    logic ext_clk_sel;
    logic [1:0] sram_pwr;
    logic io_hold;
    logic [3:0] bus_div;
    logic [3:0] flash_div;
  } pwr_s;

endpackage

// ---- hw/low_power_mode_controller.sv ----
module low_power_mode_controller
  import lp_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wfi_i,
  input wire logic sleepdeep_i,
  input wire logic wake_irq_i,
  input wire logic leakage_wake_unit_wake_i,
  output pwr_s pwr_o,
  output logic wake_reset_o,
  output logic leakage_wake_unit_flag_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // wake inputs come from pins and always-on logic
  // ------------------------------------------------------------
  logic [1:0] irq_sync_q;
  logic [1:0] leakage_wake_unit_sync_q;
  logic wake_irq;
  logic leakage_wake_unit_wake;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sync_q <= 2'h0;
      leakage_wake_unit_sync_q <= 2'h0;
    end else begin
      irq_sync_q <= {irq_sync_q[0], wake_irq_i};
      leakage_wake_unit_sync_q <= {leakage_wake_unit_sync_q[0], leakage_wake_unit_wake_i};
    end
  end

  assign wake_irq = irq_sync_q[1];
  assign leakage_wake_unit_wake = leakage_wake_unit_sync_q[1];

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  ctrl_s ctrl_q;
  logic deep0_q;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic bus_req;
  logic bus_wr;
  pm_state_e state_q;
  pm_state_e state_d;
  stop_sel_e mode_q;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      if (wb_adr_i == OFS_CTRL) begin
        wb_dat_o <= {23'h00_0000, deep0_q, ctrl_q};
      end else if (wb_adr_i == OFS_STATE) begin
        wb_dat_o <= {24'h00_0000, leakage_wake_unit_flag_o, mode_q, 1'b0, state_q};
      end else if (wb_adr_i == OFS_IRQ_STATUS) begin
        wb_dat_o <= {29'h0000_0000, irq_stat_q};
      end else if (wb_adr_i == OFS_IRQ_MASK) begin
        wb_dat_o <= {29'h0000_0000, irq_mask_q};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= ctrl_s'(CTRL_RESET);
    end else if (bus_wr && wb_adr_i == OFS_CTRL) begin
      ctrl_q <= ctrl_s'(wb_dat_i[7:0]);
    end
  end

  // deep stop 0 has no room in the two-bit field, so it sits in bit 8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep0_q <= 1'b0;
    end else if (bus_req && wb_we_i && wb_sel_i[1] && wb_adr_i == OFS_CTRL) begin
      deep0_q <= wb_dat_i[8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= IRQ_RESET;
    end else if (bus_wr && wb_adr_i == OFS_IRQ_MASK) begin
      irq_mask_q <= wb_dat_i[IRQ_BITS-1:0];
    end
  end

  // ------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------
  logic wake_event;
  logic from_deep_q;

  always_comb begin
    wake_event = 1'b0;
    if (state_q == ST_WAIT) begin
      wake_event = wake_irq;
    end else if (state_q == ST_STOP) begin
      if (mode_q == STOP_VERY_LOW_POWER_STOP) begin
        wake_event = wake_irq;
      end else begin
        wake_event = leakage_wake_unit_wake;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (wfi_i) begin
          state_d = sleepdeep_i ? ST_STOP : ST_WAIT;
        end
      end
      ST_WAIT, ST_STOP: begin
        if (wake_event) begin
          state_d = ST_RESTORE;
        end
      end
      ST_RESTORE: state_d = ST_RELEASE;
      ST_RELEASE: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // the stop flavour is frozen at entry so a late register write cannot
  // change SRAM power or wake path while the chip is asleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= STOP_VERY_LOW_POWER_STOP;
    end else if (state_q == ST_RUN && wfi_i && sleepdeep_i) begin
      mode_q <= ctrl_q.stop_sel == 2'h3 ? (deep0_q ? STOP_DEEP_LEAKAGE_STOP_0 : STOP_DEEP_LEAKAGE_STOP_1)
        : stop_sel_e'({1'b0, ctrl_q.stop_sel});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      from_deep_q <= 1'b0;
    end else if (state_q == ST_STOP && wake_event) begin
      from_deep_q <= mode_q inside {STOP_DEEP_LEAKAGE_STOP_3, STOP_DEEP_LEAKAGE_STOP_1, STOP_DEEP_LEAKAGE_STOP_0};
    end else if (state_q == ST_RUN) begin
      from_deep_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // power settings per state
  // ------------------------------------------------------------
  pwr_s pwr_d;
  logic lp;

  assign lp = ctrl_q.low_power_run;

  always_comb begin
    pwr_d = '0;
    pwr_d.sys_clk_en = 1'b1;
    pwr_d.nested_interrupt_ctrl_en = 1'b1;
    pwr_d.periph_clk_en = 1'b1;
    pwr_d.tpm_clk_en = 1'b1;
    pwr_d.uart_clk_en = 1'b1;
    pwr_d.adc_en = 1'b1;
    pwr_d.osc_en = 1'b1;
    pwr_d.cmp_en = 1'b1;
    pwr_d.sram_pwr = 2'h3;
    pwr_d.lvd_en = !lp;
    pwr_d.reg_low_power = lp;
    pwr_d.ext_clk_sel = lp && ctrl_q.ext_clk;
    pwr_d.bus_div = lp ? BUS_DIV : DIV_FULL;
    pwr_d.flash_div = lp ? FLASH_DIV : DIV_FULL;
    case (state_q)
      ST_WAIT: begin
        pwr_d.core_sleep = 1'b1;
      end
      ST_STOP: begin
        pwr_d.core_sleep = 1'b1;
        pwr_d.core_deep = 1'b1;
        pwr_d.sys_clk_en = 1'b0;
        pwr_d.nested_interrupt_ctrl_en = 1'b0;
        pwr_d.periph_clk_en = 1'b0;
        pwr_d.lvd_en = 1'b0;
        pwr_d.reg_low_power = 1'b1;
        pwr_d.io_hold = 1'b1;
        pwr_d.tpm_clk_en = 1'b0;
        pwr_d.uart_clk_en = 1'b0;
        pwr_d.adc_en = 1'b0;
        if (mode_q == STOP_VERY_LOW_POWER_STOP) begin
          pwr_d.async_wake_ctrl_en = 1'b1;
          pwr_d.adc_en = 1'b1;
          pwr_d.tpm_clk_en = ctrl_q.tpm_en && ctrl_q.tpm_clk_en;
          pwr_d.uart_clk_en = ctrl_q.uart_en && ctrl_q.uart_clk_en;
        end else begin
          pwr_d.leakage_wake_unit_en = 1'b1;
        end
        if (mode_q inside {STOP_DEEP_LEAKAGE_STOP_1, STOP_DEEP_LEAKAGE_STOP_0}) begin
          pwr_d.sram_pwr = 2'h0;
        end
        if (mode_q == STOP_DEEP_LEAKAGE_STOP_0) begin
          pwr_d.osc_en = 1'b0;
          pwr_d.cmp_en = 1'b0;
        end
      end
      ST_RESTORE: begin
        pwr_d.core_sleep = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_o <= '0;
      pwr_o.sys_clk_en <= 1'b1;
      pwr_o.nested_interrupt_ctrl_en <= 1'b1;
      pwr_o.periph_clk_en <= 1'b1;
      pwr_o.tpm_clk_en <= 1'b1;
      pwr_o.uart_clk_en <= 1'b1;
      pwr_o.adc_en <= 1'b1;
      pwr_o.osc_en <= 1'b1;
      pwr_o.cmp_en <= 1'b1;
      pwr_o.lvd_en <= 1'b1;
      pwr_o.sram_pwr <= 2'h3;
      pwr_o.bus_div <= DIV_FULL;
      pwr_o.flash_div <= DIV_FULL;
    end else begin
      pwr_o <= pwr_d;
    end
  end

  // ------------------------------------------------------------
  // wake flow outputs and interrupts
  // ------------------------------------------------------------
  logic leakage_wake_unit_set;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;

  assign leakage_wake_unit_set = state_q == ST_STOP && wake_event && mode_q != STOP_VERY_LOW_POWER_STOP;

  // deep stops lose the core context, so they come back through reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_reset_o <= 1'b0;
    end else begin
      wake_reset_o <= state_q == ST_RESTORE && from_deep_q;
    end
  end

  // held until software acknowledges the wake source, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      leakage_wake_unit_flag_o <= 1'b0;
    end else if (leakage_wake_unit_set) begin
      leakage_wake_unit_flag_o <= 1'b1;
    end else if (bus_wr && wb_adr_i == OFS_IRQ_STATUS && wb_dat_i[IRQ_WAKE_LEAKAGE_WAKE_UNIT]) begin
      leakage_wake_unit_flag_o <= 1'b0;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_WAKE_INT] = wake_event && !leakage_wake_unit_set;
    irq_set[IRQ_WAKE_LEAKAGE_WAKE_UNIT] = leakage_wake_unit_set;
    irq_set[IRQ_STOP_ENTRY] = state_q == ST_RUN && wfi_i && sleepdeep_i;
    irq_clr = '0;
    if (bus_wr && wb_adr_i == OFS_IRQ_STATUS) begin
      irq_clr = wb_dat_i[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= IRQ_RESET;
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_set | (irq_stat_q & ~irq_clr)) & irq_mask_q);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_lpr_flash_slow: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_RUN && lp) |=> (pwr_o.flash_div == FLASH_DIV && !pwr_o.lvd_en))
    else $error("low-power run flash rate or detection wrong");

  a_lpr_bus_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_RUN && lp) |=> (pwr_o.bus_div > 4'h5 && pwr_o.reg_low_power))
    else $error("low-power run bus divider too small");

  a_wait_wakes_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_WAIT && wake_irq) |=> state_q == ST_RESTORE ##1 state_q == ST_RELEASE ##2 !pwr_o.core_sleep)
    else $error("wait did not return to run on interrupt");

  a_very_low_power_stop_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && mode_q == STOP_VERY_LOW_POWER_STOP) |=> (!pwr_o.periph_clk_en && pwr_o.adc_en && pwr_o.async_wake_ctrl_en))
    else $error("low-power stop gating wrong");

  a_very_low_power_stop_tpm_opt: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && mode_q == STOP_VERY_LOW_POWER_STOP) |=> pwr_o.tpm_clk_en == $past(ctrl_q.tpm_en && ctrl_q.tpm_clk_en))
    else $error("timer clock in low-power stop not as enabled");

  a_stop_nested_interrupt_ctrl_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP) |=> (!pwr_o.sys_clk_en && !pwr_o.nested_interrupt_ctrl_en && pwr_o.core_deep))
    else $error("stop left system clock or irq controller on");

  a_sram_retained: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && mode_q inside {STOP_VERY_LOW_POWER_STOP, STOP_LLS, STOP_DEEP_LEAKAGE_STOP_3}) |=> (pwr_o.sram_pwr == 2'h3 && pwr_o.io_hold))
    else $error("SRAM or pins not retained");

  a_deep_leakage_stop_1_sram_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && mode_q == STOP_DEEP_LEAKAGE_STOP_1) |=> (pwr_o.sram_pwr == 2'h0 && pwr_o.osc_en))
    else $error("deep stop 1 SRAM power wrong");

  a_deep_leakage_stop_0_analog: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && mode_q == STOP_DEEP_LEAKAGE_STOP_0) |=> (!pwr_o.osc_en && !pwr_o.cmp_en && pwr_o.leakage_wake_unit_en))
    else $error("deep stop 0 left oscillator or comparator on");

  a_deep_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && leakage_wake_unit_wake && mode_q inside {STOP_DEEP_LEAKAGE_STOP_3, STOP_DEEP_LEAKAGE_STOP_1, STOP_DEEP_LEAKAGE_STOP_0}) |=> ##1 (wake_reset_o && leakage_wake_unit_flag_o))
    else $error("deep stop exit missed wake reset or flag");

  a_lls_no_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == ST_STOP && leakage_wake_unit_wake && mode_q == STOP_LLS) |=> ##1 (!wake_reset_o && leakage_wake_unit_flag_o))
    else $error("retention stop exit took wrong path");

  a_entry_on_wfi: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pwr_o.core_sleep) |-> $past(state_q == ST_WAIT || state_q == ST_STOP, 1) && $past(wfi_i, 2))
    else $error("core slept without wait instruction");

  a_clk_before_rel: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(pwr_o.core_sleep) |-> $past(pwr_o.periph_clk_en && pwr_o.sys_clk_en))
    else $error("core released before clocks restored");

endmodule

// ---- testbench/core_model.sv ----
module core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic deep_i,
  input wire logic core_sleep_i,
  output logic wfi_o,
  output logic sleepdeep_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic leakage_wake_unit_irq_en_q;

  // ------------------------------------------------------------
  // instruction issue
  // ------------------------------------------------------------
  // a sleeping core fetches nothing, so no second wfi while asleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wfi_o <= 1'b0;
      sleepdeep_o <= 1'b0;
    end else begin
      wfi_o <= req_i & ~core_sleep_i;
      if (req_i) begin
        sleepdeep_o <= deep_i;
      end
    end
  end

  // the interrupt controller never masks the wake unit line
  always_ff @(posedge clk_i) begin
    leakage_wake_unit_irq_en_q <= 1'b1;
  end
endmodule

// ---- testbench/low_power_mode_controller_tb.sv ----
module low_power_mode_controller_tb
  import lp_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic wait_for_interrupt_instr;
  logic deep;
  logic req = 1'b0;
  logic deep_req = 1'b0;
  logic wake_irq = 1'b0;
  logic leakage_wake_unit_wake = 1'b0;
  pwr_s pwr;
  logic wake_reset;
  logic leakage_wake_unit_flag;
  logic irq;
  int failures = 0;
  int cmp_count = 0;
  int rst_cnt = 0;
  logic [31:0] rd;

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  low_power_mode_controller DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wfi_i(wait_for_interrupt_instr), .sleepdeep_i(deep), .wake_irq_i(wake_irq), .leakage_wake_unit_wake_i(leakage_wake_unit_wake), .pwr_o(pwr),
    .wake_reset_o(wake_reset), .leakage_wake_unit_flag_o(leakage_wake_unit_flag), .irq_o(irq));

  core_model core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .deep_i(deep_req),
    .core_sleep_i(pwr.core_sleep), .wfi_o(wait_for_interrupt_instr), .sleepdeep_o(deep));

  always_ff @(posedge clk_i) begin
    if (wake_reset === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic summarize();
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask

  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (pwr.core_sleep !== lvl && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask

  task automatic fire(input logic d);
    @(posedge clk_i);
    req <= 1'b1;
    deep_req <= d;
    @(posedge clk_i);
    req <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    int base;
    logic [8:0] ctrl;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("sram_rst", pwr.sram_pwr, 32'h3);
    chk("lvd_rst", pwr.lvd_en, 32'h1);
    chk("sleep_rst", pwr.core_sleep, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
    chk("ctrl_rst", rd, 32'h0);
    wb(1'b0, OFS_IRQ_MASK, 32'h0, 4'hF);
    chk("mask_rst", rd, 32'h0);
    wb(1'b1, 8'h10, 32'hFF, 4'hF);
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, OFS_CTRL, 32'hFF, 4'hE);
    wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
    chk("sel_lane", rd, 32'h0);
    // stray deep request without req (no wfi, sleepdeep stays low) must not sleep the core
    deep_req <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("no_wfi", pwr.core_sleep, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h09, 4'hF);
    repeat (2) @(posedge clk_i);
    chk("bus_div", pwr.bus_div, 32'h6);
    chk("flash_div", pwr.flash_div, 32'h4);
    chk("lvd_lpr", pwr.lvd_en, 32'h0);
    chk("reg_lp", pwr.reg_low_power, 32'h1);
    chk("ext_clk", pwr.ext_clk_sel, 32'h1);
    wb(1'b1, OFS_CTRL, 32'h01, 4'hF);
    repeat (2) @(posedge clk_i);
    chk("int_clk", pwr.ext_clk_sel, 32'h0);
    fire(1'b0);
    wait_sleep(1'b1);
    chk("w_sys_clk", pwr.sys_clk_en, 32'h1);
    chk("w_nested_interrupt_ctrl", pwr.nested_interrupt_ctrl_en, 32'h1);
    chk("w_reg_lp", pwr.reg_low_power, 32'h1);
    chk("w_bus_div", pwr.bus_div, 32'h6);
    wake_irq <= 1'b1;
    wait_sleep(1'b0);
    wake_irq <= 1'b0;
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hF);
    chk("w_status", rd[0], 32'h1);
    wb(1'b1, OFS_IRQ_STATUS, 32'h7, 4'hF);
    for (int s = 0; s < 5; s++) begin
      ctrl = (s == 0) ? 9'h071 : (s == 4) ? 9'h107 : {6'h0, 2'(s), 1'b1};
      wb(1'b1, OFS_CTRL, {23'h0, ctrl}, 4'hF);
      base = rst_cnt;
      fire(1'b1);
      wait_sleep(1'b1);
      chk("sys_clk", pwr.sys_clk_en, 32'h0);
      chk("nested_interrupt_ctrl", pwr.nested_interrupt_ctrl_en, 32'h0);
      chk("periph", pwr.periph_clk_en, 32'h0);
      chk("sram", pwr.sram_pwr, (s >= 3) ? 32'h0 : 32'h3);
      chk("core_deep", pwr.core_deep, 32'h1);
      chk("io_hold", pwr.io_hold, 32'h1);
      chk("async_wake_ctrl", pwr.async_wake_ctrl_en, 32'(s == 0));
      chk("leakage_wake_unit", pwr.leakage_wake_unit_en, 32'(s != 0));
      chk("osc", pwr.osc_en, 32'(s != 4));
      chk("cmp", pwr.cmp_en, 32'(s != 4));
      chk("tpm_clk", pwr.tpm_clk_en, 32'(s == 0));
      chk("uart_clk", pwr.uart_clk_en, 32'h0);
      chk("lvd", pwr.lvd_en, 32'h0);
      chk("adc", pwr.adc_en, 32'(s == 0));
      wb(1'b0, OFS_STATE, 32'h0, 4'hF);
      chk("state", rd, 32'(s * 16 + 2));
      if (s == 0) begin
        wake_irq <= 1'b1;
      end else begin
        leakage_wake_unit_wake <= 1'b1;
      end
      n = 0;
      while (pwr.periph_clk_en !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 50) begin
        failures++;
        summarize();
      end
      chk("restore", pwr.core_sleep, 32'h1);
      wait_sleep(1'b0);
      wake_irq <= 1'b0;
      leakage_wake_unit_wake <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("wake_rst", 32'(rst_cnt - base), 32'(s >= 2));
      chk("leakage_wake_unit_flag", leakage_wake_unit_flag, 32'(s != 0));
      wb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hF);
      chk("status", rd[2:0], {29'h0, 1'b1, 1'(s != 0), 1'(s == 0)});
      if (s == 0) begin
        chk("irq_masked", irq, 32'h0);
        wb(1'b1, OFS_IRQ_MASK, 32'h4, 4'hF);
        repeat (2) @(posedge clk_i);
        chk("irq_set", irq, 32'h1);
      end
      wb(1'b1, OFS_IRQ_STATUS, 32'h7, 4'hF);
      repeat (2) @(posedge clk_i);
      chk("irq_clr", irq, 32'h0);
      chk("flag_clr", leakage_wake_unit_flag, 32'h0);
    end
    summarize();
  end
endmodule
